// file: duar_cfg.svh
// Constants of the dual serial auxiliary register bank
// How it works
// - Carrier status bit is inverted carrier pin
// - Loopback: carrier status follows modem control bit3
// - Scratch byte read/write, reset to FF
// - Divisor is high byte over low byte
// - Bit rate is clock over 16 over divisor
// - Concurrent bit set writes both channels
// - Concurrent bit writable from either channel
// - Channel select still picks read channel
// - Function select picks multifunction pin source
// - Alternate function bits 7:3 read zero
// - Reset values of registers and outputs
// - Reset clears change flags, status from inputs
// - Modem control bit4 enables internal loopback
// - Divisor mapped at data addresses when bit7 set
`ifndef DUAR_CFG_SVH
`define DUAR_CFG_SVH
// ****************************************
// Host addresses
// ****************************************
`define DUAR_A_DATA 3'h0
`define DUAR_A_IER 3'h1
`define DUAR_A_ISR 3'h2
`define DUAR_A_LCR 3'h3
`define DUAR_A_MCR 3'h4
`define DUAR_A_LSR 3'h5
`define DUAR_A_MSR 3'h6
`define DUAR_A_SPR 3'h7
// ****************************************
// Storage indices
// ****************************************
`define DUAR_I_DLL 3'h0
`define DUAR_I_DLM 3'h1
`define DUAR_I_IER 3'h2
`define DUAR_I_FCR 3'h3
`define DUAR_I_LCR 3'h4
`define DUAR_I_MCR 3'h5
`define DUAR_I_AFR 3'h6
`define DUAR_I_SPR 3'h7
// ****************************************
// Reset values and fields
// ****************************************
`define DUAR_RST_ZERO 8'h00
`define DUAR_RST_SPR 8'hFF
`define DUAR_RST_ISR 8'h01
`define DUAR_RST_LSR 8'h60
`define DUAR_AFR_MASK 8'h07
`define DUAR_LCR_DLAB 7
`define DUAR_LCR_BREAK 6
`define DUAR_MCR_DTR 0
`define DUAR_MCR_RTS 1
`define DUAR_MCR_OP1 2
`define DUAR_MCR_OP2 3
`define DUAR_MCR_LOOP 4
`define DUAR_AFR_CW 0
`define DUAR_OVS_LAST 4'hF
`define DUAR_DIV_ONE 16'h0001
`endif

// file: duar_pkg.sv
// Types of the dual serial auxiliary register bank
package duar_pkg;
	typedef enum logic [1:0] {
		DUAR_MF_OP2 = 2'b00,
		DUAR_MF_BAUD = 2'b01,
		DUAR_MF_RECEIVE_READY_N = 2'b10,
		DUAR_MF_RSVD = 2'b11
	} duar_mf_t;
	typedef enum logic [1:0] {
		DUAR_IDLE = 2'b00,
		DUAR_HOLD = 2'b01,
		DUAR_WRITE = 2'b10
	} duar_bus_t;
	typedef enum logic [2:0] {
		DUAR_SRC_MEM = 3'b000,
		DUAR_SRC_ZERO = 3'b001,
		DUAR_SRC_ISR = 3'b010,
		DUAR_SRC_LSR = 3'b011,
		DUAR_SRC_MSR = 3'b100
	} duar_src_t;
endpackage

// file: duar_regs_if.sv
// Carrier between the bus logic and the register store
`timescale 1ns/100ps
`default_nettype none
interface duar_regs_if;
	logic [1:0] we;
	logic [1:0][2:0] widx;
	logic [7:0] wdata;
	logic cw_we;
	logic cw_val;
	logic rchan;
	logic [2:0] ridx;
	logic [7:0] rdata;
	logic [1:0][7:0] dll;
	logic [1:0][7:0] baud_divisor_high;
	logic [1:0][7:0] line_control;
	logic [1:0][7:0] modem_output_control;
	logic [1:0][7:0] alternate_function_control;
	logic [1:0][7:0] scratch_storage;
	modport ctl(output we, widx, wdata, cw_we, cw_val, rchan, ridx,
		input rdata, dll, baud_divisor_high, line_control, modem_output_control, alternate_function_control, scratch_storage);
	modport store(input we, widx, wdata, cw_we, cw_val, rchan, ridx,
		output rdata, dll, baud_divisor_high, line_control, modem_output_control, alternate_function_control, scratch_storage);
endinterface
`default_nettype wire

// file: duar_regstore.sv
// Register storage of both channels
`timescale 1ns/100ps
`default_nettype none
`include "duar_cfg.svh"
module duar_regstore (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register access
	duar_regs_if.store rif
);
	import duar_pkg::*;

	logic [7:0] mem_reg [2][8];
	logic [7:0] mem_next [2][8];
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	function automatic logic [7:0] rst_val(input int idx);
		rst_val = (idx == 7) ? `DUAR_RST_SPR : `DUAR_RST_ZERO;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		mem_next = mem_reg;
		for (int c = 0; c < 2; c++) begin
			if (rif.we[c]) begin
				if (rif.widx[c] == `DUAR_I_AFR)
					mem_next[c][rif.widx[c]] = rif.wdata & `DUAR_AFR_MASK;
				else
					mem_next[c][rif.widx[c]] = rif.wdata;
			end
			if (rif.cw_we)
				mem_next[c][`DUAR_I_AFR][`DUAR_AFR_CW] = rif.cw_val;
		end
		rdata_next = mem_reg[rif.rchan][rif.ridx];
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < 2; c++)
				for (int i = 0; i < 8; i++)
					mem_reg[c][i] <= rst_val(i);
			rdata_reg <= `DUAR_RST_ZERO;
		end else begin
			mem_reg <= mem_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rif.rdata = rdata_reg;
	for (genvar c = 0; c < 2; c++) begin : g_exp
		assign rif.dll[c] = mem_reg[c][`DUAR_I_DLL];
		assign rif.baud_divisor_high[c] = mem_reg[c][`DUAR_I_DLM];
		assign rif.line_control[c] = mem_reg[c][`DUAR_I_LCR];
		assign rif.modem_output_control[c] = mem_reg[c][`DUAR_I_MCR];
		assign rif.alternate_function_control[c] = mem_reg[c][`DUAR_I_AFR];
		assign rif.scratch_storage[c] = mem_reg[c][`DUAR_I_SPR];
	end
endmodule
`default_nettype wire

// file: duar_top.sv
// Dual serial auxiliary register bank, host bus and pin logic
`timescale 1ns/100ps
`default_nettype none
`include "duar_cfg.svh"
module duar_top (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RSTN,
	// Host bus
	input wire logic CS_N,
	input wire logic IOR_N,
	input wire logic IOW_N,
	input wire logic CHSEL,
	input wire logic [2:0] ADDR,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE,
	// Modem inputs per channel
	input wire logic [1:0] CTS_N,
	input wire logic [1:0] DSR_N,
	input wire logic [1:0] RI_N,
	input wire logic [1:0] CD_N,
	input wire logic [1:0] RECEIVE_READY_N_N,
	// Pin outputs per channel
	output logic [1:0] TX,
	output logic [1:0] MF_N,
	output logic [1:0] RTS_N,
	output logic [1:0] DTR_N,
	output logic [1:0] TRANSMIT_READY_N_N,
	output logic [1:0] INT,
	output logic [1:0] BIT_TICK
);
	import duar_pkg::*;
	duar_regs_if rif();
	duar_regstore u_store (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.rif(rif)
	);
	// Returns {valid, storage index}
	function automatic logic [3:0] dec(input logic [2:0] a, input logic dlab);
		case (a)
			`DUAR_A_DATA: dec = dlab ? {1'b1, `DUAR_I_DLL} : 4'h0;
			`DUAR_A_IER: dec = {1'b1, dlab ? `DUAR_I_DLM : `DUAR_I_IER};
			`DUAR_A_ISR: dec = {1'b1, dlab ? `DUAR_I_AFR : `DUAR_I_FCR};
			`DUAR_A_LCR: dec = {1'b1, `DUAR_I_LCR};
			`DUAR_A_MCR: dec = {1'b1, `DUAR_I_MCR};
			`DUAR_A_SPR: dec = {1'b1, `DUAR_I_SPR};
			default: dec = 4'h0;
		endcase
	endfunction
	// ****************************************
	// Host write sequencing
	// ****************************************
	duar_bus_t st_reg, st_next;
	logic [2:0] wa_reg, wa_next;
	logic [7:0] wd_reg, wd_next;
	logic wc_reg, wc_next;
	logic wr_strobe, wr_go, cw;
	logic [3:0] dw0, dw1;
	assign wr_strobe = !CS_N && !IOW_N;
	assign wr_go = st_reg == DUAR_WRITE;
	assign cw = rif.alternate_function_control[0][`DUAR_AFR_CW];
	always_comb begin
		st_next = st_reg;
		wa_next = wa_reg;
		wd_next = wd_reg;
		wc_next = wc_reg;
		case (st_reg)
			DUAR_IDLE: if (wr_strobe) st_next = DUAR_HOLD;
			DUAR_HOLD: begin
				if (wr_strobe) begin
					wa_next = ADDR;
					wd_next = DATA_IN;
					wc_next = CHSEL;
				end else begin
					st_next = DUAR_WRITE;
				end
			end
			DUAR_WRITE: st_next = DUAR_IDLE;
			default: st_next = DUAR_IDLE;
		endcase
	end
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_reg <= DUAR_IDLE;
			wa_reg <= 3'h0;
			wd_reg <= 8'h00;
			wc_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			wa_reg <= wa_next;
			wd_reg <= wd_next;
			wc_reg <= wc_next;
		end
	end
	assign dw0 = dec(wa_reg, rif.line_control[0][`DUAR_LCR_DLAB]);
	assign dw1 = dec(wa_reg, rif.line_control[1][`DUAR_LCR_DLAB]);
	assign rif.widx[0] = dw0[2:0];
	assign rif.widx[1] = dw1[2:0];
	assign rif.we[0] = wr_go && dw0[3] && (cw || !wc_reg);
	assign rif.we[1] = wr_go && dw1[3] && (cw || wc_reg);
	assign rif.wdata = wd_reg;
	assign rif.cw_we = wr_go && (wc_reg ? (dw1 == {1'b1, `DUAR_I_AFR})
		: (dw0 == {1'b1, `DUAR_I_AFR}));
	assign rif.cw_val = wd_reg[`DUAR_AFR_CW];
	// ****************************************
	// Host reads
	// ****************************************
	logic rd_strobe, rd_start, rd_dlab;
	logic rd_prev_reg, rd_prev_next;
	logic r1_reg, r1_next;
	duar_src_t src_reg, src_next;
	logic [7:0] msr_snap_reg, msr_snap_next;
	logic [7:0] dout_reg, dout_next;
	logic [3:0] dr;
	logic [1:0][3:0] stat, delta_reg, delta_next, prev_reg, prev_next;
	logic primed_reg, primed_next;
	assign rd_strobe = !CS_N && !IOR_N;
	assign rd_start = rd_strobe && !rd_prev_reg;
	assign rd_dlab = rif.line_control[CHSEL][`DUAR_LCR_DLAB];
	assign dr = dec(ADDR, rd_dlab);
	assign rif.rchan = CHSEL;
	assign rif.ridx = dr[2:0];
	always_comb begin
		rd_prev_next = rd_strobe;
		r1_next = rd_start;
		src_next = src_reg;
		msr_snap_next = msr_snap_reg;
		dout_next = dout_reg;
		if (rd_start) begin
			msr_snap_next = {stat[CHSEL], delta_reg[CHSEL]};
			case (ADDR)
				`DUAR_A_DATA: src_next = rd_dlab ? DUAR_SRC_MEM : DUAR_SRC_ZERO;
				`DUAR_A_ISR: src_next = rd_dlab ? DUAR_SRC_MEM : DUAR_SRC_ISR;
				`DUAR_A_LSR: src_next = DUAR_SRC_LSR;
				`DUAR_A_MSR: src_next = DUAR_SRC_MSR;
				default: src_next = DUAR_SRC_MEM;
			endcase
		end
		if (r1_reg) begin
			case (src_reg)
				DUAR_SRC_MEM: dout_next = rif.rdata;
				DUAR_SRC_ISR: dout_next = `DUAR_RST_ISR;
				DUAR_SRC_LSR: dout_next = `DUAR_RST_LSR;
				DUAR_SRC_MSR: dout_next = msr_snap_reg;
				default: dout_next = `DUAR_RST_ZERO;
			endcase
		end
	end
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rd_prev_reg <= 1'b0;
			r1_reg <= 1'b0;
			src_reg <= DUAR_SRC_MEM;
			msr_snap_reg <= 8'h00;
			dout_reg <= 8'h00;
		end else begin
			rd_prev_reg <= rd_prev_next;
			r1_reg <= r1_next;
			src_reg <= src_next;
			msr_snap_reg <= msr_snap_next;
			dout_reg <= dout_next;
		end
	end
	assign DATA_OUT = dout_reg;
	assign DATA_OE = rd_strobe;
	// ****************************************
	// Modem status, change flags
	// ****************************************
	always_comb begin
		delta_next = delta_reg;
		prev_next = stat;
		primed_next = 1'b1;
		for (int c = 0; c < 2; c++) begin
			if (rif.modem_output_control[c][`DUAR_MCR_LOOP])
				stat[c] = {rif.modem_output_control[c][`DUAR_MCR_OP2],
					rif.modem_output_control[c][`DUAR_MCR_OP1],
					rif.modem_output_control[c][`DUAR_MCR_DTR], rif.modem_output_control[c][`DUAR_MCR_RTS]};
			else
				stat[c] = ~{CD_N[c], RI_N[c], DSR_N[c], CTS_N[c]};
			if (rd_start && ADDR == `DUAR_A_MSR && CHSEL == c && !rd_dlab)
				delta_next[c] = 4'h0;
			if (primed_reg)
				delta_next[c] = delta_next[c] | {stat[c][3] ^ prev_reg[c][3],
					prev_reg[c][2] & !stat[c][2],
					stat[c][1:0] ^ prev_reg[c][1:0]};
		end
	end
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			delta_reg <= 8'h00;
			prev_reg <= 8'h00;
			primed_reg <= 1'b0;
		end else begin
			delta_reg <= delta_next;
			prev_reg <= prev_next;
			primed_reg <= primed_next;
		end
	end
	// ****************************************
	// Baud generation and pin outputs
	// ****************************************
	logic [1:0][15:0] div, cnt_reg, cnt_next;
	logic [1:0][3:0] ovs_reg, ovs_next;
	logic [1:0] tick16;
	logic [1:0] tx_next, mf_next, rts_next, dtr_next, bt_next;
	logic [1:0] tx_reg, mf_reg, rts_reg, dtr_reg, bt_reg;
	logic [19:0] gap_reg, gap_next;
	always_comb begin
		gap_next = rif.we[0] ? 20'h0_0000 : (bt_reg[0] ? 20'h0_0001
			: (gap_reg == 20'h0_0000 ? 20'h0_0000 : gap_reg + 20'h0_0001));
		for (int c = 0; c < 2; c++) begin
			div[c] = {rif.baud_divisor_high[c], rif.dll[c]};
			tick16[c] = (div[c] != 16'h0000)
				&& (cnt_reg[c] >= div[c] - `DUAR_DIV_ONE);
			cnt_next[c] = tick16[c] ? 16'h0000
				: (div[c] == 16'h0000 ? 16'h0000 : cnt_reg[c] + 16'h0001);
			ovs_next[c] = tick16[c] ? ovs_reg[c] + 4'h1 : ovs_reg[c];
			bt_next[c] = tick16[c] && ovs_reg[c] == `DUAR_OVS_LAST;
			tx_next[c] = !rif.line_control[c][`DUAR_LCR_BREAK];
			rts_next[c] = rif.modem_output_control[c][`DUAR_MCR_LOOP]
				|| !rif.modem_output_control[c][`DUAR_MCR_RTS];
			dtr_next[c] = rif.modem_output_control[c][`DUAR_MCR_LOOP]
				|| !rif.modem_output_control[c][`DUAR_MCR_DTR];
			case (duar_mf_t'(rif.alternate_function_control[c][2:1]))
				DUAR_MF_OP2: mf_next[c] = rif.modem_output_control[c][`DUAR_MCR_LOOP]
					|| !rif.modem_output_control[c][`DUAR_MCR_OP2];
				DUAR_MF_BAUD: mf_next[c] = !tick16[c];
				DUAR_MF_RECEIVE_READY_N: mf_next[c] = RECEIVE_READY_N_N[c];
				default: mf_next[c] = 1'b1;
			endcase
		end
	end
	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cnt_reg <= 32'h0000_0000;
			gap_reg <= 20'h0_0000;
			ovs_reg <= 8'h00;
			bt_reg <= 2'h0;
			tx_reg <= 2'h3;
			mf_reg <= 2'h3;
			rts_reg <= 2'h3;
			dtr_reg <= 2'h3;
		end else begin
			cnt_reg <= cnt_next;
			gap_reg <= gap_next;
			ovs_reg <= ovs_next;
			bt_reg <= bt_next;
			tx_reg <= tx_next;
			mf_reg <= mf_next;
			rts_reg <= rts_next;
			dtr_reg <= dtr_next;
		end
	end
	assign TX = tx_reg;
	assign MF_N = mf_reg;
	assign RTS_N = rts_reg;
	assign DTR_N = dtr_reg;
	assign BIT_TICK = bt_reg;
	// Transmitter and interrupt logic sit elsewhere; held at reset level
	assign TRANSMIT_READY_N_N = 2'h0;
	assign INT = 2'h0;
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	a_cd_from_pin: assert property (!rif.modem_output_control[0][4] |-> stat[0][3] == !CD_N[0])
		else $error("carrier status not inverted pin");
	a_cd_loopback: assert property (rif.modem_output_control[1][4] |-> stat[1][3] == rif.modem_output_control[1][3])
		else $error("carrier status not following loopback bit");
	a_spr_read_back: assert property (rd_start && ADDR == 3'h7 |-> ##2
		DATA_OUT == $past(rif.scratch_storage[CHSEL], 2))
		else $error("scratch read wrong");
	a_baud_period: assert property (tick16[0] && div[0] == 16'h0102 |=>
		!tick16[0] ##257 (tick16[0] || $changed(div[0])))
		else $error("divisor period wrong");
	a_bit_rate: assert property (bt_reg[0] && gap_reg != 20'h0_0000 |->
		gap_reg == {div[0], 4'h0})
		else $error("bit rate wrong");
	a_cw_both: assert property (wr_go && cw && dw0[3] && dw1[3] |->
		rif.we == 2'b11)
		else $error("concurrent write missed a channel");
	a_single_chan: assert property (wr_go && !cw |-> !rif.we[!wc_reg])
		else $error("write leaked to other channel");
	a_mf_op2: assert property (rif.alternate_function_control[0][2:1] == 2'b00 |=>
		MF_N[0] == $past(rif.modem_output_control[0][4] || !rif.modem_output_control[0][3]))
		else $error("multifunction pin wrong");
	a_afr_reserved: assert property (rif.alternate_function_control[0][7:3] == 5'h00
		&& rif.alternate_function_control[1][7:3] == 5'h00)
		else $error("reserved function bits set");
	a_reset_out: assert property ($rose(RSTN) |-> TX == 2'h3 && MF_N == 2'h3
		&& INT == 2'h0)
		else $error("outputs not at reset level");
	c_concurrent: cover property (wr_go && cw && rif.we == 2'b11);
	c_msr_read: cover property (rd_start && ADDR == 3'h6);
	c_loopback: cover property (rif.modem_output_control[0][4] && rif.modem_output_control[0][3]);
	c_bit_tick: cover property (bt_reg[0]);
endmodule
`default_nettype wire

// file: duar_host_model.sv
// Host processor model driving the parallel register bus
`timescale 1ns/100ps
`default_nettype none
module duar_host_model (
	// Clock
	input wire logic clk,
	// Host bus
	output var logic cs_n,
	output var logic ior_n,
	output var logic iow_n,
	output var logic chsel,
	output var logic [2:0] addr,
	output var logic [7:0] wdata,
	// Read data
	input wire logic [7:0] rdata
);
	initial begin
		cs_n = 1'b1;
		ior_n = 1'b1;
		iow_n = 1'b1;
		chsel = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
	end
	// ****************************************
	// Write: strobe low two cycles, then idle three
	// ****************************************
	task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		iow_n <= 1'b0;
		chsel <= ch;
		addr <= a;
		wdata <= d;
		repeat (2) @(posedge clk);
		cs_n <= 1'b1;
		iow_n <= 1'b1;
		chsel <= ~ch;
		addr <= ~a;
		wdata <= ~d;
		repeat (3) @(posedge clk);
	endtask
	// ****************************************
	// Read: data taken after the third edge
	// ****************************************
	task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		ior_n <= 1'b0;
		chsel <= ch;
		addr <= a;
		repeat (3) @(posedge clk);
		#1;
		d = rdata;
		@(posedge clk);
		cs_n <= 1'b1;
		ior_n <= 1'b1;
		chsel <= ~ch;
		addr <= ~a;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// file: dual_uart_aux_registers_bench.sv
// Self-checking bench of the dual serial auxiliary register bank
`timescale 1ns/100ps
`default_nettype none
module dual_uart_aux_registers_bench;
	logic SYS_CLK = 1'b0;
	logic RSTN = 1'b0;
	logic cs_n, ior_n, iow_n, chsel, oe;
	logic [2:0] addr;
	logic [7:0] din, dout, rv;
	logic [1:0] cts_n = 2'b11;
	logic [1:0] dsr_n = 2'b00;
	logic [1:0] ri_n = 2'b11;
	logic [1:0] cd_n = 2'b00;
	logic [1:0] receive_ready_n_n = 2'b11;
	logic [1:0] tx, mf_n, rts_n, dtr_n, transmit_ready_n_n, intr, tick;
	logic [7:0] rst_exp [1:7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'ha0,
		8'hff};
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	int n, lows;
	always #2 SYS_CLK = ~SYS_CLK;
	duar_host_model host (.clk(SYS_CLK), .cs_n(cs_n), .ior_n(ior_n),
		.iow_n(iow_n), .chsel(chsel), .addr(addr), .wdata(din),
		.rdata(dout));
	duar_top dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CS_N(cs_n),
		.IOR_N(ior_n), .IOW_N(iow_n), .CHSEL(chsel), .ADDR(addr),
		.DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .CTS_N(cts_n),
		.DSR_N(dsr_n), .RI_N(ri_n), .CD_N(cd_n), .RECEIVE_READY_N_N(receive_ready_n_n),
		.TX(tx), .MF_N(mf_n), .RTS_N(rts_n), .DTR_N(dtr_n),
		.TRANSMIT_READY_N_N(transmit_ready_n_n), .INT(intr), .BIT_TICK(tick));
	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic ch, input logic [2:0] a,
		input logic [7:0] m, input logic [7:0] e);
		host.rd(ch, a, rv);
		check({8'h00, rv & m}, {8'h00, e});
	endtask
	task automatic settle();
		repeat (3) @(posedge SYS_CLK);
		#1;
	endtask
	task automatic wait_tick();
		n = 0;
		lows = 0;
		do begin
			@(posedge SYS_CLK);
			#1;
			n++;
			if (mf_n[0] === 1'b0) lows++;
		end while (tick[0] !== 1'b1 && n < 9000);
	endtask
	task automatic finish_test();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			finish_test();
		end
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge SYS_CLK);
		RSTN <= 1'b1;
		@(posedge SYS_CLK);
		#1;
		check({8'h00, tx, mf_n, rts_n, dtr_n}, 16'h00ff);
		check({11'h000, oe, transmit_ready_n_n, intr}, 16'h0000);
		for (int c = 0; c < 2; c++) begin
			for (int a = 1; a < 8; a++) begin
				rchk(c[0], a[2:0], 8'hff, rst_exp[a]);
			end
		end
		host.wr(1'b0, 3'h7, 8'h5a);
		rchk(1'b0, 3'h7, 8'hff, 8'h5a);
		rchk(1'b1, 3'h7, 8'hff, 8'hff);
		@(posedge SYS_CLK);
		cd_n[0] <= 1'b1;
		settle();
		rchk(1'b0, 3'h6, 8'h80, 8'h00);
		host.wr(1'b0, 3'h4, 8'h18);
		rchk(1'b0, 3'h6, 8'h80, 8'h80);
		host.wr(1'b0, 3'h4, 8'h10);
		rchk(1'b0, 3'h6, 8'h80, 8'h00);
		host.wr(1'b0, 3'h4, 8'h08);
		rchk(1'b0, 3'h6, 8'h80, 8'h00);
		check({15'h0000, mf_n[0]}, 16'h0000);
		host.wr(1'b0, 3'h3, 8'h80);
		host.wr(1'b0, 3'h0, 8'h02);
		host.wr(1'b0, 3'h1, 8'h01);
		host.wr(1'b0, 3'h2, 8'hfa);
		rchk(1'b0, 3'h0, 8'hff, 8'h02);
		rchk(1'b0, 3'h1, 8'hff, 8'h01);
		rchk(1'b0, 3'h2, 8'hff, 8'h02);
		repeat (3) wait_tick();
		check(n[15:0], 16'h1020);
		check(lows[15:0], 16'h0010);
		host.wr(1'b0, 3'h2, 8'h04);
		@(posedge SYS_CLK);
		receive_ready_n_n[0] <= 1'b0;
		settle();
		check({15'h0000, mf_n[0]}, 16'h0000);
		@(posedge SYS_CLK);
		receive_ready_n_n[0] <= 1'b1;
		settle();
		check({15'h0000, mf_n[0]}, 16'h0001);
		host.wr(1'b1, 3'h3, 8'h80);
		host.wr(1'b1, 3'h2, 8'h01);
		rchk(1'b0, 3'h2, 8'hff, 8'h05);
		rchk(1'b0, 3'h7, 8'hff, 8'h5a);
		rchk(1'b1, 3'h7, 8'hff, 8'hff);
		host.wr(1'b0, 3'h7, 8'h77);
		rchk(1'b1, 3'h7, 8'hff, 8'h77);
		host.wr(1'b0, 3'h2, 8'h04);
		rchk(1'b1, 3'h2, 8'hff, 8'h04);
		host.wr(1'b1, 3'h7, 8'h33);
		rchk(1'b0, 3'h7, 8'hff, 8'h77);
		host.wr(1'b0, 3'h3, 8'h00);
		rchk(1'b0, 3'h1, 8'hff, 8'h00);
		rchk(1'b0, 3'h0, 8'hff, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
